// ==== design/fbrp_top.sv ====
`timescale 1ns/100ps
// Operation
// - Address captured at strobe rising edge, then addressed word is driven.
// - All banks read array until a command register write changes it.
// - Reset puts the state machine into array reading.
// - Start asynchronous; after burst configuration only synchronous reads are taken.
// - First word after initial latency; each later active edge advances address.
// - Continuous burst adds two cycles at each 64-word boundary, ready low.
// - Standard handshaking devices skip the boundary gap.
// - Reduced handshaking: start low bits 3Dh add one initial cycle.
// - Reduced handshaking: 3Eh adds two initial cycles, skips next boundary gap.
// - Reduced handshaking: 3Fh adds three initial cycles, skips next boundary gap.
// - Continuous burst wraps at top; ends on chip enable, reset, new address.
// - Crossing into an idle bank adds the two-cycle gap.
// - Crossing into a busy bank returns status and ignores the clock.
// - Burst clock below 6 MHz adds latency shown by ready low.
// - Wrapped 8/16/32 modes stay in the aligned group, wrapping to its start.
// - Wrapped modes never cross the 64-word boundary, so no later boundary gaps.
// - Configuration holds wait states, mode, edge, ready timing, sync enable.
// - Reduced handshaking marks the first word by ready rising.
// - Standard handshaking adds one clock for odd start addresses.
// - Reads run in one bank while another programs or erases.
// - Ready low when data is not valid, high when valid.
// - Rising burst clock edge is active by default.

// ------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter.
// ------------------------------------------------------------
module fbrp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// A change counts only once the second and third stages agree.
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			s1 <= RST;
			s2 <= RST;
			s3 <= RST;
			o_level <= RST;
		end else begin
			s1 <= i_async;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				o_level <= s3;
			end
		end
	end
endmodule

// ------------------------------------------------------------
// Burst read port top.
// ------------------------------------------------------------
module fbrp_top #(
	parameter bit REDUCED_WAIT = 1'b1,
	parameter int SLOW_EXTRA_WAIT = 1
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [fbrp_pkg::ADDR_W-1:0] i_addr_lines,
	input wire logic i_addr_latch_strobe_n,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_burst_clk,
	output logic [fbrp_pkg::DATA_W-1:0] o_data_lines,
	output logic o_data_lines_oe_n,
	output logic o_ready,
	output logic [fbrp_pkg::ADDR_W-1:0] o_array_addr,
	input wire logic [fbrp_pkg::DATA_W-1:0] i_array_data,
	input wire logic [fbrp_pkg::DATA_W-1:0] i_status_word,
	input wire logic [3:0] i_bank_busy,
	input wire logic i_erase_suspended,
	input wire logic [fbrp_pkg::ADDR_W-fbrp_pkg::SECTOR_LSB-1:0] i_suspend_sector
);
	localparam int AW = fbrp_pkg::ADDR_W;

	fbrp_pkg::fbrp_pins_s pins;
	fbrp_pkg::fbrp_cfg_s cfg;
	fbrp_pkg::fbrp_state_e state;
	logic [AW-1:0] addr_f;
	logic [AW-1:0] cur_addr;
	logic [AW-1:0] nxt;
	logic [7:0] cmd;
	logic [5:0] gap;
	logic [5:0] adv_gap;
	logic [7:0] period_cnt;
	logic [31:0] rd_word;
	logic rd_err;
	logic skip_bound;
	logic strobe_d;
	logic clk_d;
	logic strobe_rise;
	logic clk_edge;
	logic run;
	logic adv;
	logic slow;
	logic bank_cross;
	logic busy_cur;
	logic busy_nxt;
	logic show_status;
	logic ready_now;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// ------------------------------------------------------------
	// Pin synchronisers and edge detection.
	// ------------------------------------------------------------
	fbrp_sync #(.W(AW), .RST('0)) u_addr_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_addr_lines),
		.o_level(addr_f)
	);
	fbrp_sync #(.W(5), .RST(fbrp_pkg::PINS_RST)) u_pin_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_addr_latch_strobe_n, i_ce_n, i_oe_n, i_we_n, i_burst_clk}),
		.o_level(pins)
	);

	// Previous filtered levels for edge detection.
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			strobe_d <= 1'b1;
			clk_d <= 1'b0;
		end else begin
			strobe_d <= pins.strobe_n;
			clk_d <= pins.clk;
		end
	end

	// Strobe rising edge latches; the configured burst clock edge steps the burst.
	assign strobe_rise = pins.strobe_n && !strobe_d;
	assign clk_edge = cfg.falling_edge ? (clk_d && !pins.clk) : (pins.clk && !clk_d);
	assign run = !pins.ce_n && pins.strobe_n && !strobe_rise;

	// ------------------------------------------------------------
	// Address helpers.
	// ------------------------------------------------------------
	// A location is busy if its bank is programming, or it lies in a suspended sector.
	function automatic logic busy_at(input logic [AW-1:0] a);
		return i_bank_busy[a[AW-1:fbrp_pkg::BANK_LSB]] ||
			(i_erase_suspended && a[AW-1:fbrp_pkg::SECTOR_LSB] == i_suspend_sector);
	endfunction

	// Initial latency in active edges for a latched start address.
	function automatic logic [5:0] init_lat(input logic [AW-1:0] a, input logic [3:0] ws);
		logic [5:0] x;
		x = {2'h0, ws};
		if (REDUCED_WAIT) begin
			if (a[5:0] == fbrp_pkg::LOW_3D) begin
				x = x + 6'h01;
			end else if (a[5:0] == fbrp_pkg::LOW_3E) begin
				x = x + 6'h02;
			end else if (a[5:0] == fbrp_pkg::LOW_3F) begin
				x = x + 6'h03;
			end
		end else begin
			x = x + {5'h00, a[0]};
		end
		return x;
	endfunction

	// Next burst address; wrapped modes keep the upper bits of the group.
	function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a, input logic [1:0] m);
		logic [AW-1:0] n;
		n = a + 1'b1;
		case (m)
			fbrp_pkg::MODE_W8: n = {a[AW-1:3], n[2:0]};
			fbrp_pkg::MODE_W16: n = {a[AW-1:4], n[3:0]};
			fbrp_pkg::MODE_W32: n = {a[AW-1:5], n[4:0]};
			default: n = n;
		endcase
		return n;
	endfunction

	// Advance decisions: boundary, bank crossing and slow clock gaps.
	assign nxt = step_addr(cur_addr, cfg.mode);
	assign busy_cur = busy_at(cur_addr);
	assign busy_nxt = busy_at(nxt);
	assign bank_cross = nxt[AW-1:fbrp_pkg::BANK_LSB] != cur_addr[AW-1:fbrp_pkg::BANK_LSB];
	assign slow = period_cnt >= fbrp_pkg::SLOW_PERIOD_CNT;
	assign adv = state == fbrp_pkg::ST_BURST && clk_edge && run && gap == 6'h00;
	always_comb begin
		adv_gap = 6'h00;
		if (bank_cross) begin
			adv_gap = fbrp_pkg::GAP_CYC;
		end else if (REDUCED_WAIT && cfg.mode == fbrp_pkg::MODE_CONT &&
				cur_addr[5:0] == fbrp_pkg::LOW_3F && !skip_bound) begin
			adv_gap = fbrp_pkg::GAP_CYC;
		end
		if (slow) begin
			adv_gap = adv_gap + 6'(SLOW_EXTRA_WAIT);
		end
	end

	// ------------------------------------------------------------
	// Burst clock period measurement.
	// ------------------------------------------------------------
	// Counts system cycles between active edges, saturating at the slow limit.
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			period_cnt <= 8'h00;
		end else if (clk_edge) begin
			period_cnt <= 8'h01;
		end else if (!slow) begin
			period_cnt <= period_cnt + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Read sequencer.
	// ------------------------------------------------------------
	// Latches addresses, counts latency and gaps, and steps the burst address.
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			state <= fbrp_pkg::ST_IDLE;
			cur_addr <= '0;
			gap <= 6'h00;
			skip_bound <= 1'b0;
		end else if (pins.ce_n) begin
			state <= fbrp_pkg::ST_IDLE;
		end else if (strobe_rise) begin
			cur_addr <= addr_f;
			gap <= init_lat(addr_f, cfg.wait_states);
			skip_bound <= REDUCED_WAIT &&
				(addr_f[5:0] == fbrp_pkg::LOW_3E || addr_f[5:0] == fbrp_pkg::LOW_3F);
			if (cfg.sync_en && busy_at(addr_f)) begin
				state <= fbrp_pkg::ST_STATUS;
			end else if (cfg.sync_en) begin
				state <= fbrp_pkg::ST_WAIT;
			end else begin
				state <= fbrp_pkg::ST_ASYNC;
			end
		end else if (!pins.strobe_n && state != fbrp_pkg::ST_ASYNC) begin
			state <= fbrp_pkg::ST_IDLE;
		end else if (clk_edge) begin
			case (state)
				fbrp_pkg::ST_WAIT: begin
					if (gap == 6'h00) begin
						state <= fbrp_pkg::ST_BURST;
					end else begin
						gap <= gap - 6'h01;
					end
				end
				fbrp_pkg::ST_BURST: begin
					if (gap != 6'h00) begin
						gap <= gap - 6'h01;
					end else begin
						cur_addr <= nxt;
						if (busy_nxt) begin
							state <= fbrp_pkg::ST_STATUS;
						end else begin
							gap <= adv_gap;
						end
						if (cur_addr[5:0] == fbrp_pkg::LOW_3F) begin
							skip_bound <= 1'b0;
						end
					end
				end
				default: state <= state;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Data, ready and output enable.
	// ------------------------------------------------------------
	// Status replaces array data for busy locations or any non-read command.
	assign show_status = state == fbrp_pkg::ST_STATUS || cmd != fbrp_pkg::CMD_READ_ARRAY ||
		busy_cur;

	// Ready is low through latency and gaps; early timing looks one edge ahead.
	always_comb begin
		case (state)
			fbrp_pkg::ST_WAIT: ready_now = cfg.ready_early && gap == 6'h00;
			fbrp_pkg::ST_BURST: ready_now = cfg.ready_early ? gap <= 6'h01 : gap == 6'h00;
			default: ready_now = 1'b1;
		endcase
	end

	// Data, ready and enable outputs lag the sequencer one cycle, matching the array read delay; the array address does not.
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_data_lines <= '0;
			o_data_lines_oe_n <= 1'b1;
			o_ready <= 1'b1;
		end else begin
			o_data_lines <= show_status ? i_status_word : i_array_data;
			o_data_lines_oe_n <= pins.ce_n || pins.oe_n || !pins.we_n;
			o_ready <= ready_now;
		end
	end
	assign o_array_addr = cur_addr;

	// ------------------------------------------------------------
	// APB register slave.
	// ------------------------------------------------------------
	// Read word and unmapped address decode.
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_err = 1'b0;
		case (i_paddr)
			fbrp_pkg::OFS_CFG: rd_word = 32'(cfg);
			fbrp_pkg::OFS_CMD: rd_word = 32'(cmd);
			fbrp_pkg::OFS_STATUS: rd_word = 32'({skip_bound, cfg.sync_en, state});
			fbrp_pkg::OFS_ADDR: rd_word = 32'(cur_addr);
			default: rd_err = 1'b1;
		endcase
	end

	// Answer in the first access cycle, with no wait states.
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && rd_err;
			o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rd_word : 32'h0000_0000;
		end
	end

	// Configuration and command writes take effect at the completing edge.
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			cfg <= fbrp_pkg::CFG_RST;
			cmd <= fbrp_pkg::CMD_READ_ARRAY;
		end else if (i_psel && i_penable && o_pready && i_pwrite) begin
			case (i_paddr)
				fbrp_pkg::OFS_CFG: cfg <= fbrp_pkg::fbrp_cfg_s'(i_pwdata[fbrp_pkg::CFG_W-1:0]);
				fbrp_pkg::OFS_CMD: cmd <= i_pwdata[7:0];
				default: cmd <= cmd;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	a_addr_capture:
	assert property (strobe_rise && !pins.ce_n |=> cur_addr == $past(addr_f))
		else $error("latched address differs from pins");
	a_reset_array:
	assert property (@(posedge i_clk) disable iff (1'b0)
		!i_reset_n |=> state == fbrp_pkg::ST_IDLE && cmd == fbrp_pkg::CMD_READ_ARRAY)
		else $error("reset did not return to array read");
	a_sync_only:
	assert property (strobe_rise && !pins.ce_n && cfg.sync_en |=> state != fbrp_pkg::ST_ASYNC)
		else $error("async read accepted in sync mode");
	a_bank_read:
	assert property (state == fbrp_pkg::ST_ASYNC && cmd == fbrp_pkg::CMD_READ_ARRAY && !busy_cur
		&& !pins.ce_n |=> o_data_lines == $past(i_array_data))
		else $error("array data not returned");
	a_busy_status:
	assert property (state == fbrp_pkg::ST_ASYNC && busy_cur |=> o_data_lines == $past(i_status_word))
		else $error("busy location did not return status");
	a_first_word:
	assert property (state == fbrp_pkg::ST_WAIT && clk_edge && run && gap == 6'h00
		|=> state == fbrp_pkg::ST_BURST && $stable(cur_addr) ##1 o_data_lines_oe_n || o_ready)
		else $error("first burst word not presented");
	a_boundary_gap:
	assert property (adv && REDUCED_WAIT && cfg.mode == fbrp_pkg::MODE_CONT && !busy_nxt &&
		cur_addr[5:0] == fbrp_pkg::LOW_3F && !skip_bound |=> gap >= fbrp_pkg::GAP_CYC)
		else $error("boundary gap missing");
	a_std_no_gap:
	assert property (adv && !REDUCED_WAIT && !bank_cross && !slow && !busy_nxt |=> gap == 6'h00)
		else $error("standard device inserted a gap");
	a_lat_3d:
	assert property (strobe_rise && !pins.ce_n && REDUCED_WAIT && addr_f[5:0] == fbrp_pkg::LOW_3D
		|=> gap == {2'h0, $past(cfg.wait_states)} + 6'h01)
		else $error("3Dh start latency wrong");
	a_lat_3e:
	assert property (strobe_rise && !pins.ce_n && REDUCED_WAIT && addr_f[5:0] == fbrp_pkg::LOW_3E
		|=> gap == {2'h0, $past(cfg.wait_states)} + 6'h02 && skip_bound)
		else $error("3Eh start latency wrong");
	a_lat_3f:
	assert property (strobe_rise && !pins.ce_n && REDUCED_WAIT && addr_f[5:0] == fbrp_pkg::LOW_3F
		|=> gap == {2'h0, $past(cfg.wait_states)} + 6'h03 && skip_bound)
		else $error("3Fh start latency wrong");
	a_odd_delay:
	assert property (strobe_rise && !pins.ce_n && !REDUCED_WAIT && addr_f[0]
		|=> gap == {2'h0, $past(cfg.wait_states)} + 6'h01)
		else $error("odd start delay missing");
	a_bank_gap:
	assert property (adv && bank_cross && !busy_nxt |=> gap >= fbrp_pkg::GAP_CYC)
		else $error("bank crossing gap missing");
	a_status_hold:
	assert property (state == fbrp_pkg::ST_STATUS && clk_edge && run |=> $stable(cur_addr)
		##1 o_data_lines == $past(i_status_word))
		else $error("clock not ignored in status");
	a_wrap_group:
	assert property (adv && cfg.mode != fbrp_pkg::MODE_CONT |=> cur_addr[AW-1:5] == $past(cur_addr[AW-1:5]))
		else $error("wrapped burst left its group");
	a_ready_gap:
	assert property (state == fbrp_pkg::ST_BURST && gap > 6'h01 |=> !o_ready)
		else $error("ready high during gap");
endmodule

// ==== design/fbrp_pkg.sv ====
package fbrp_pkg;
	// ------------------------------------------------------------
	// Sizes and timing.
	// ------------------------------------------------------------
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int BANK_LSB = 20;
	localparam int SECTOR_LSB = 15;
	localparam int CLK_MHZ = 100;
	localparam int SLOW_CLK_MHZ = 6;
	// System cycles in one burst clock period at the slow limit, rounded up.
	localparam int SLOW_PERIOD_CYC = (CLK_MHZ + SLOW_CLK_MHZ - 1) / SLOW_CLK_MHZ;
	localparam logic [7:0] SLOW_PERIOD_CNT = 8'(SLOW_PERIOD_CYC);
	localparam logic [5:0] GAP_CYC = 6'h02;

	// ------------------------------------------------------------
	// Register map and reset values.
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_CFG = 12'h000;
	localparam logic [11:0] OFS_CMD = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_ADDR = 12'h00C;
	localparam logic [7:0] CMD_READ_ARRAY = 8'h00;
	localparam int CFG_W = 9;

	// ------------------------------------------------------------
	// Address points and burst modes.
	// ------------------------------------------------------------
	localparam logic [5:0] LOW_3D = 6'h3D;
	localparam logic [5:0] LOW_3E = 6'h3E;
	localparam logic [5:0] LOW_3F = 6'h3F;
	localparam logic [1:0] MODE_CONT = 2'h0;
	localparam logic [1:0] MODE_W8 = 2'h1;
	localparam logic [1:0] MODE_W16 = 2'h2;
	localparam logic [1:0] MODE_W32 = 2'h3;

	// Configuration word, bit 0 upward: wait states, mode, edge, ready timing, sync.
	typedef struct packed {
		logic sync_en;
		logic ready_early;
		logic falling_edge;
		logic [1:0] mode;
		logic [3:0] wait_states;
	} fbrp_cfg_s;
	localparam fbrp_cfg_s CFG_RST = fbrp_cfg_s'(9'h005);

	// Host control pins after synchronisation.
	typedef struct packed {
		logic strobe_n;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic clk;
	} fbrp_pins_s;
	localparam logic [4:0] PINS_RST = 5'h1E;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ASYNC = 5'h02,
		ST_WAIT = 5'h04,
		ST_BURST = 5'h08,
		ST_STATUS = 5'h10
	} fbrp_state_e;
endpackage

// ==== verification/fbrp_host_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Host memory controller model driving the flash pins.
// ------------------------------------------------------------
module fbrp_host_model (
	input wire logic i_clk,
	input wire logic [15:0] i_data,
	input wire logic i_ready,
	output logic [21:0] o_addr,
	output logic o_strobe_n,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic o_bclk
);
	logic [15:0] dat_q[$];
	logic rdy_q[$];

	// Pins start deselected with the burst clock parked low.
	initial begin
		o_addr = 22'h155555;
		o_strobe_n = 1'b1;
		o_ce_n = 1'b1;
		o_oe_n = 1'b1;
		o_we_n = 1'b1;
		o_bclk = 1'b0;
	end

	// Present an address under strobe, then let the address go stale after the hold time.
	task automatic latch(input logic [21:0] a);
		@(posedge i_clk);
		o_addr <= a;
		o_strobe_n <= 1'b0;
		o_ce_n <= 1'b0;
		o_oe_n <= 1'b0;
		o_we_n <= 1'b1;
		repeat (6) @(posedge i_clk);
		o_strobe_n <= 1'b1;
		repeat (6) @(posedge i_clk);
		o_addr <= ~a;
	endtask

	// Give n active edges; ready and data are sampled just before each next edge.
	task automatic burst(input int n, input int half);
		dat_q.delete();
		rdy_q.delete();
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			o_bclk <= 1'b1;
			repeat (half) @(posedge i_clk);
			o_bclk <= 1'b0;
			repeat (half - 1) @(posedge i_clk);
			@(negedge i_clk);
			rdy_q.push_back(i_ready);
			dat_q.push_back(i_data);
		end
	endtask

	// Deselecting the chip ends any burst; bursts stay short so no relatch is overdue.
	task automatic stop();
		@(posedge i_clk);
		o_ce_n <= 1'b1;
		o_oe_n <= 1'b1;
		repeat (8) @(posedge i_clk);
	endtask
endmodule

// ==== verification/tb_flash_burst_read_port.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Self-checking bench for the burst read port.
// ------------------------------------------------------------
module tb_flash_burst_read_port;
	logic i_clk;
	logic i_reset_n;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [21:0] addr;
	logic strobe_n;
	logic ce_n;
	logic oe_n;
	logic we_n;
	logic bclk;
	logic [15:0] data;
	logic data_oe_n;
	logic ready;
	logic [21:0] array_addr;
	logic [15:0] array_data;
	logic [15:0] status_word;
	logic [3:0] bank_busy;
	logic [31:0] rd;
	logic err;
	int miscompares;
	int checks;
	logic erase_susp;
	logic [15:0] data_std;
	logic [21:0] array_addr_std;

	// The array returns a scrambled copy of the low address bits.
	assign array_data = array_addr[15:0] ^ 16'h5A00;

	fbrp_top uut (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_addr_lines(addr),
		.i_addr_latch_strobe_n(strobe_n), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_burst_clk(bclk), .o_data_lines(data), .o_data_lines_oe_n(data_oe_n),
		.o_ready(ready), .o_array_addr(array_addr), .i_array_data(array_data),
		.i_status_word(status_word), .i_bank_busy(bank_busy),
		.i_erase_suspended(erase_susp), .i_suspend_sector(7'h01)
	);

	fbrp_host_model host (
		.i_clk(i_clk), .i_data(data), .i_ready(ready), .o_addr(addr),
		.o_strobe_n(strobe_n), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_bclk(bclk)
	);

	// A standard handshaking copy on the same pins exercises its own latency checks.
	fbrp_top #(.REDUCED_WAIT(1'b0)) uut_std (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(),
		.o_pready(), .o_pslverr(), .i_addr_lines(addr),
		.i_addr_latch_strobe_n(strobe_n), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_burst_clk(bclk), .o_data_lines(data_std), .o_data_lines_oe_n(),
		.o_ready(), .o_array_addr(array_addr_std),
		.i_array_data(array_addr_std[15:0] ^ 16'h5A00),
		.i_status_word(status_word), .i_bank_busy(bank_busy),
		.i_erase_suspended(erase_susp), .i_suspend_sector(7'h01)
	);

	// Clock of 100 MHz.
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Compare one value and count it.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One APB transfer; the request holds until pready is seen at a rising edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge i_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge i_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			check("pready", 32'h0, 32'h1);
		end
	endtask

	// Asynchronous read: latch, then wait a bounded time for the expected word.
	task automatic aread(input logic [21:0] a, input logic [15:0] exp);
		int n;
		n = 0;
		host.latch(a);
		while (data !== exp && n < 40) begin
			@(negedge i_clk);
			n++;
		end
		check("async data", {16'h0000, data}, {16'h0000, exp});
		check("data enable", {31'h0, data_oe_n}, 32'h0);
		check("std async data", {16'h0000, data_std}, {16'h0000, exp});
		host.stop();
	endtask

	// Next burst address for continuous or wrapped modes.
	function automatic logic [21:0] step(input logic [21:0] a, input logic [1:0] m);
		logic [21:0] sz;
		sz = (m == fbrp_pkg::MODE_CONT) ? 22'h000000 : (22'h000004 << m);
		if (sz == 22'h000000) begin
			return a + 22'h000001;
		end
		return (a & ~(sz - 22'h000001)) | ((a + 22'h000001) & (sz - 22'h000001));
	endfunction

	// One synchronous burst; the first word comes after two wait states plus the start penalty.
	task automatic burst_case(input logic [21:0] s, input logic [1:0] m, input int n,
		input int extra, input int gap, input logic fe);
		logic [21:0] a;
		int fi;
		int lows;
		fi = -1;
		lows = 0;
		a = s;
		apb(1'b1, fbrp_pkg::OFS_CFG, {23'h0, 1'b1, 1'b0, fe, m, 4'h2});
		host.latch(s);
		host.burst(n, 8);
		for (int i = 0; i < n; i++) begin
			if (host.rdy_q[i] === 1'b1) begin
				if (fi < 0) begin
					fi = i;
				end
				check("word", {16'h0, host.dat_q[i]}, {16'h0, a[15:0] ^ 16'h5A00});
				a = step(a, m);
			end else if (fi >= 0) begin
				lows++;
			end
		end
		check("first word", 32'(fi), 32'(2 + extra));
		check("mid gap", 32'(lows), 32'(gap));
		host.stop();
		$display("burst test from %h done", s);
	endtask

	// Watchdog: the tests need well under 20000 cycles.
	initial begin
		#200000;
		miscompares++;
		$display("watchdog expired");
		results();
	end

	// Main sequence.
	initial begin
		i_reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		status_word = 16'hC3C3;
		bank_busy = 4'h0;
		miscompares = 0;
		checks = 0;
		erase_susp = 1'b0;
		repeat (8) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (4) @(posedge i_clk);

		apb(1'b0, fbrp_pkg::OFS_CFG, 32'h0);
		check("cfg reset", rd, 32'(fbrp_pkg::CFG_RST));
		apb(1'b0, fbrp_pkg::OFS_CMD, 32'h0);
		check("cmd reset", rd, 32'h00000000);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
		check("unmapped data", rd, 32'h00000000);
		$display("register test done");

		bank_busy <= 4'h2;
		aread(22'h012345, 16'h2345 ^ 16'h5A00);
		apb(1'b1, fbrp_pkg::OFS_CMD, 32'h00000070);
		aread(22'h000100, 16'hC3C3);
		apb(1'b1, fbrp_pkg::OFS_CMD, 32'h00000000);
		aread(22'h000101, 16'h0101 ^ 16'h5A00);
		erase_susp <= 1'b1;
		aread(22'h008000, 16'hC3C3);
		erase_susp <= 1'b0;
		bank_busy <= 4'h0;
		$display("async test done");

		burst_case(22'h000010, fbrp_pkg::MODE_CONT, 12, 0, 0, 1'b0);
		burst_case(22'h00003D, fbrp_pkg::MODE_CONT, 12, 1, 2, 1'b0);
		burst_case(22'h00003E, fbrp_pkg::MODE_CONT, 12, 2, 0, 1'b0);
		burst_case(22'h00007F, fbrp_pkg::MODE_CONT, 12, 3, 0, 1'b0);
		burst_case(22'h000039, fbrp_pkg::MODE_W8, 14, 0, 0, 1'b0);
		burst_case(22'h000069, fbrp_pkg::MODE_W16, 20, 0, 0, 1'b0);
		burst_case(22'h00003A, fbrp_pkg::MODE_W32, 14, 0, 0, 1'b0);
		burst_case(22'h000020, fbrp_pkg::MODE_CONT, 8, 0, 0, 1'b1);
		burst_case(22'h3FFFFE, fbrp_pkg::MODE_CONT, 10, 2, 2, 1'b0);
		apb(1'b0, fbrp_pkg::OFS_STATUS, 32'h0);
		check("sync enabled", {31'h0, rd[5]}, 32'h1);

		bank_busy <= 4'h2;
		host.latch(22'h0FFFFC);
		host.burst(12, 8);
		check("busy bank", {16'h0, host.dat_q[11]}, 32'h0000C3C3);
		host.stop();
		bank_busy <= 4'h0;
		$display("busy bank test done");

		// A reset in mid-run must return command and configuration to array reading.
		apb(1'b1, fbrp_pkg::OFS_CMD, 32'h00000070);
		i_reset_n <= 1'b0;
		repeat (8) @(posedge i_clk);
		i_reset_n <= 1'b1;
		apb(1'b0, fbrp_pkg::OFS_CMD, 32'h0);
		check("cmd after reset", rd, 32'h00000000);
		apb(1'b0, fbrp_pkg::OFS_CFG, 32'h0);
		check("cfg after reset", rd, 32'(fbrp_pkg::CFG_RST));
		$display("reset test done");
		results();
	end
endmodule
